// ==== rtl/ext_ctrl_io.sv ====
// external control lines: input detection, output reporting, APB registers
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ext_ctrl_map.svh"

module ext_ctrl_io
(
    input  wire logic                     clk_in,
    input  wire logic                     resetn_in,
    input  wire logic                     psel_in,
    input  wire logic                     penable_in,
    input  wire logic                     pwrite_in,
    input  wire logic [`ADDR_WIDTH-1:0]   paddr_in,
    input  wire logic [31:0]              pwdata_in,
    output logic      [31:0]              prdata_out,
    output logic                          pready_out,
    output logic                          pslverr_out,
    input  wire logic [`LINE_COUNT-1:0]   ext_ctrl_line_in,
    output logic      [`LINE_COUNT-1:0]   ext_ctrl_line_out,
    output logic      [`LINE_COUNT-1:0]   ext_ctrl_line_oe_out,
    output logic      [`CHAN_COUNT-1:0]   supply_channel_on_out
);

    // ****************************************
    // functions
    // ****************************************

    // address decode: index 0..4 lines, 5 status, 6 channel, 7 unmapped
    function automatic logic [2:0] reg_index(input logic [`ADDR_WIDTH-1:0] a);
        logic [2:0] idx;
        idx = 3'h7;
        if (a[1:0] == 2'h0 && a <= `OFS_CHAN_ON)
        begin
            idx = a[4:2];
        end
        return idx;
    endfunction : reg_index

    // packs a line configuration into a bus word
    function automatic logic [31:0] cfg_word(input ext_ctrl_pkg::line_cfg_s c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`FLD_EN]                 = c.en;
        w[`FLD_DIR]                = c.dir_out;
        w[`FLD_MASK_LO +: 4]       = c.mask;
        w[`FLD_TYPE_LO +: 3]       = c.det;
        w[`FLD_SENS_LO +: 2]       = c.sens;
        w[`FLD_RESP_LO +: 2]       = c.resp;
        w[`FLD_SRC_LO +: 2]        = c.src;
        w[`FLD_COND]               = c.cond;
        w[`FLD_POL]                = c.pol;
        return w;
    endfunction : cfg_word

    // ****************************************
    // state
    // ****************************************
    ext_ctrl_pkg::line_cfg_s  cfg      [`LINE_COUNT];
    ext_ctrl_pkg::line_cfg_s  next_cfg [`LINE_COUNT];
    ext_ctrl_pkg::chan_req_s  req      [`LINE_COUNT];
    logic [`CHAN_COUNT-1:0]   chan_on;
    logic [`CHAN_COUNT-1:0]   next_chan_on;
    logic [`LINE_COUNT-1:0]   level;
    logic [`LINE_COUNT-1:0]   hit;
    logic [`LINE_COUNT-1:0]   drive;
    logic [`LINE_COUNT-1:0]   next_drive;
    logic [`LINE_COUNT-1:0]   oe;
    logic [`LINE_COUNT-1:0]   next_oe;
    logic [31:0]              rdata;
    logic [31:0]              next_rdata;
    logic [2:0]               idx;
    logic                     wr_take;

    assign idx     = reg_index(paddr_in);
    assign wr_take = psel_in & penable_in & pwrite_in;

    // slave always ready; read data captured in the setup cycle
    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in & penable_in & (idx == 3'h7);
    assign prdata_out  = rdata;

    assign ext_ctrl_line_out     = drive;
    assign ext_ctrl_line_oe_out  = oe;
    assign supply_channel_on_out = chan_on;

    // ****************************************
    // per-line input detection and output line drive
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < `LINE_COUNT; gi++)
        begin : g_line
            logic       sync_a;
            logic       sync_b;
            logic       filt;
            logic       next_filt;
            logic       filt_d;
            logic [4:0] cnt;
            logic [4:0] next_cnt;
            logic [4:0] need;
            logic       rise;
            logic       fall;
            logic       act;
            logic       start;

            // filter length from sensitivity; fewer cycles means quicker response
            always_comb
            begin
                case (cfg[gi].sens)
                    ext_ctrl_pkg::SENS_HIGH: need = `SENS_HIGH_CYC;
                    ext_ctrl_pkg::SENS_LOW:  need = `SENS_LOW_CYC;
                    ext_ctrl_pkg::SENS_MID:  need = `SENS_MID_CYC;
                    default:                 need = `SENS_HIGH_CYC;
                endcase
            end

            // filtered value follows the synchronised input once stable long enough
            always_comb
            begin
                next_filt = filt;
                next_cnt  = 5'h00;
                if (sync_b != filt)
                begin
                    if (cnt + 5'h01 >= need)
                    begin
                        next_filt = sync_b;
                    end
                    else
                    begin
                        next_cnt = cnt + 5'h01;
                    end
                end
            end

            // two-stage synchroniser; only sync_b feeds the filter
            always_ff @(posedge clk_in or negedge resetn_in)
            begin
                if (!resetn_in)
                begin
                    sync_a <= 1'b0;
                    sync_b <= 1'b0;
                    filt   <= 1'b0;
                    filt_d <= 1'b0;
                    cnt    <= 5'h00;
                end
                else
                begin
                    sync_a <= ext_ctrl_line_in[gi];
                    sync_b <= sync_a;
                    filt   <= next_filt;
                    filt_d <= filt;
                    cnt    <= next_cnt;
                end
            end

            assign rise = filt & ~filt_d;
            assign fall = ~filt & filt_d;
            assign act  = cfg[gi].en & ~cfg[gi].dir_out;

            // level types repeat on/off each cycle but toggle only once per level
            always_comb
            begin
                hit[gi] = 1'b0;
                start   = 1'b0;
                case (cfg[gi].det)
                    ext_ctrl_pkg::DET_RISE:   begin hit[gi] = rise; start = rise; end
                    ext_ctrl_pkg::DET_FALL:   begin hit[gi] = fall; start = fall; end
                    ext_ctrl_pkg::DET_HIGH:   begin hit[gi] = filt; start = rise; end
                    ext_ctrl_pkg::DET_LOW:    begin hit[gi] = ~filt; start = fall; end
                    ext_ctrl_pkg::DET_CHANGE: begin hit[gi] = rise | fall; start = rise | fall; end
                    default:                  begin hit[gi] = 1'b0; start = 1'b0; end
                endcase
                hit[gi] = hit[gi] & act;
                start   = start & act;
            end

            // channel request of this line
            always_comb
            begin
                req[gi].set_on  = hit[gi] & (cfg[gi].resp == ext_ctrl_pkg::RESP_ON);
                req[gi].set_off = hit[gi] & (cfg[gi].resp == ext_ctrl_pkg::RESP_OFF);
                req[gi].toggle  = start & (cfg[gi].resp == ext_ctrl_pkg::RESP_TOGGLE);
            end

            assign level[gi] = filt;

            // output line: source channel state against condition, then polarity
            always_comb
            begin
                next_oe[gi]    = cfg[gi].en & cfg[gi].dir_out;
                next_drive[gi] = ((chan_on[cfg[gi].src] == cfg[gi].cond)
                                 ^ cfg[gi].pol) & next_oe[gi];
            end
        end
    endgenerate

    // ****************************************
    // configuration, channel state and read data
    // ****************************************

    // configuration writes; a running line takes only its enable bit
    always_comb
    begin
        ext_ctrl_pkg::line_cfg_s c;
        logic [3:0]              m;
        logic [2:0]              t;
        logic [1:0]              s;
        logic [1:0]              r;
        c = cfg[0];
        m = 4'h0;
        t = 3'h0;
        s = 2'h0;
        r = 2'h0;
        for (int i = 0; i < `LINE_COUNT; i++)
        begin
            next_cfg[i] = cfg[i];
            if (wr_take && idx == i[2:0])
            begin
                c    = cfg[i];
                c.en = pwdata_in[`FLD_EN];
                if (!cfg[i].en)
                begin
                    m = pwdata_in[`FLD_MASK_LO +: 4];
                    t = pwdata_in[`FLD_TYPE_LO +: 3];
                    s = pwdata_in[`FLD_SENS_LO +: 2];
                    r = pwdata_in[`FLD_RESP_LO +: 2];
                    c.dir_out = pwdata_in[`FLD_DIR];
                    if (m != 4'h0)
                    begin
                        c.mask = m;
                    end
                    if (t <= 3'(ext_ctrl_pkg::DET_CHANGE))
                    begin
                        c.det = ext_ctrl_pkg::detect_e'(t);
                    end
                    if (s != 2'h3)
                    begin
                        c.sens = ext_ctrl_pkg::sens_e'(s);
                    end
                    if (r != 2'h3)
                    begin
                        c.resp = ext_ctrl_pkg::resp_e'(r);
                    end
                    // any-change keeps only on/off; a refused toggle keeps the previous response, or off if that was toggle
                    if (c.det == ext_ctrl_pkg::DET_CHANGE
                        && c.resp == ext_ctrl_pkg::RESP_TOGGLE)
                    begin
                        c.resp = (cfg[i].resp == ext_ctrl_pkg::RESP_TOGGLE)
                               ? ext_ctrl_pkg::RESP_OFF : cfg[i].resp;
                    end
                    c.src  = pwdata_in[`FLD_SRC_LO +: 2];
                    c.cond = pwdata_in[`FLD_COND];
                    c.pol  = pwdata_in[`FLD_POL];
                end
                next_cfg[i] = c;
            end
        end
    end

    // channel state: software write first, then line requests in line order
    always_comb
    begin
        next_chan_on = chan_on;
        if (wr_take && idx == 3'h6)
        begin
            next_chan_on = pwdata_in[`CHAN_COUNT-1:0];
        end
        for (int i = 0; i < `LINE_COUNT; i++)
        begin
            if (req[i].set_on)
            begin
                next_chan_on = next_chan_on | cfg[i].mask;
            end
            if (req[i].set_off)
            begin
                next_chan_on = next_chan_on & ~cfg[i].mask;
            end
            if (req[i].toggle)
            begin
                next_chan_on = next_chan_on ^ cfg[i].mask;
            end
        end
    end

    // read data captured in the setup cycle so prdata comes from a flop
    always_comb
    begin
        next_rdata = rdata;
        if (psel_in && !penable_in && !pwrite_in)
        begin
            next_rdata = 32'h0000_0000;
            if (idx < 3'h5)
            begin
                next_rdata = cfg_word(cfg[idx]);
            end
            else if (idx == 3'h5)
            begin
                next_rdata[`FLD_ST_LEVEL_LO +: `LINE_COUNT] = level;
                next_rdata[`FLD_ST_HIT_LO +: `LINE_COUNT]   = hit;
                next_rdata[`FLD_ST_DRIVE_LO +: `LINE_COUNT] = drive;
            end
            else if (idx == 3'h6)
            begin
                next_rdata[`CHAN_COUNT-1:0] = chan_on;
            end
        end
    end

    // registers of the shared state
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            for (int i = 0; i < `LINE_COUNT; i++)
            begin
                cfg[i] <= '{en: 1'b0, dir_out: 1'b0, mask: `RST_MASK,
                           det: ext_ctrl_pkg::DET_RISE, sens: ext_ctrl_pkg::SENS_HIGH,
                           resp: ext_ctrl_pkg::RESP_OFF, src: 2'h0, cond: 1'b1,
                           pol: 1'b0};
            end
            chan_on <= `RST_CHAN_ON;
            drive   <= 5'h00;
            oe      <= 5'h00;
            rdata   <= 32'h0000_0000;
        end
        else
        begin
            for (int i = 0; i < `LINE_COUNT; i++)
            begin
                cfg[i] <= next_cfg[i];
            end
            chan_on <= next_chan_on;
            drive   <= next_drive;
            oe      <= next_oe;
            rdata   <= next_rdata;
        end
    end

endmodule : ext_ctrl_io

// ==== shared/ext_ctrl_map.svh ====
// register offsets, field positions, reset values and timing counts of the control lines
`ifndef EXT_CTRL_MAP_SVH
`define EXT_CTRL_MAP_SVH

// ****************************************
// geometry
// ****************************************
`define LINE_COUNT      5
`define CHAN_COUNT      4
`define ADDR_WIDTH      8

// ****************************************
// byte offsets
// ****************************************
`define OFS_LINE_CFG0   8'h00
`define OFS_STATUS      8'h14
`define OFS_CHAN_ON     8'h18

// ****************************************
// line configuration field positions
// ****************************************
`define FLD_EN          0
`define FLD_DIR         1
`define FLD_MASK_LO     4
`define FLD_TYPE_LO     8
`define FLD_SENS_LO     12
`define FLD_RESP_LO     16
`define FLD_SRC_LO      20
`define FLD_COND        24
`define FLD_POL         28

// ****************************************
// status field positions
// ****************************************
`define FLD_ST_LEVEL_LO 0
`define FLD_ST_HIT_LO   8
`define FLD_ST_DRIVE_LO 16

// ****************************************
// reset values
// ****************************************
`define RST_MASK        4'h1
`define RST_CHAN_ON     4'h0

// ****************************************
// input filter lengths in clock cycles per sensitivity
// ****************************************
`define SENS_HIGH_CYC   5'h01
`define SENS_MID_CYC    5'h04
`define SENS_LOW_CYC    5'h10

`endif

// ==== shared/ext_ctrl_pkg.sv ====
// types of the external control line block
package ext_ctrl_pkg;

    // detection kind of an input line
    typedef enum logic [2:0] {
        DET_RISE   = 3'h0,
        DET_FALL   = 3'h1,
        DET_HIGH   = 3'h2,
        DET_LOW    = 3'h3,
        DET_CHANGE = 3'h4
    } detect_e;

    // input sensitivity
    typedef enum logic [1:0] {
        SENS_HIGH = 2'h0,
        SENS_LOW  = 2'h1,
        SENS_MID  = 2'h2
    } sens_e;

    // channel response
    typedef enum logic [1:0] {
        RESP_OFF    = 2'h0,
        RESP_ON     = 2'h1,
        RESP_TOGGLE = 2'h2
    } resp_e;

    // configuration of one line
    typedef struct packed {
        logic       en;
        logic       dir_out;
        logic [3:0] mask;
        detect_e    det;
        sens_e      sens;
        resp_e      resp;
        logic [1:0] src;
        logic       cond;
        logic       pol;
    } line_cfg_s;

    // per-line channel request from detection
    typedef struct packed {
        logic set_on;
        logic set_off;
        logic toggle;
    } chan_req_s;

endpackage : ext_ctrl_pkg

// ==== verification/ext_ctrl_io_properties.sv ====
// port-level checks of the external control line block
`timescale 1ns/1ps

module ext_ctrl_io_properties
(
    input wire logic        clk_in,
    input wire logic        resetn_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic [4:0]  ext_ctrl_line_in,
    input wire logic [4:0]  ext_ctrl_line_out,
    input wire logic [4:0]  ext_ctrl_line_oe_out,
    input wire logic [3:0]  supply_channel_on_out
);
    logic       wr;
    logic       wr_d1;
    logic       wr_d2;
    logic       rd_d1;
    logic [3:0] chan_d1;
    logic [3:0] chan_d2;
    logic [4:0] pin_d1;
    logic [5:0] quiet;
    logic [5:0] next_quiet;

    assign wr = psel_in & penable_in & pwrite_in;

    // cycles since the last write or pin change; saturates so it never wraps
    always_comb
    begin
        next_quiet = (quiet == 6'h3F) ? quiet : quiet + 6'h01;
        if (wr || ext_ctrl_line_in != pin_d1)
            next_quiet = 6'h00;
    end

    // delayed copies of the causes
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            {wr_d1, wr_d2, rd_d1, chan_d1, chan_d2, pin_d1, quiet} <= '0;
        else
        begin
            wr_d1   <= wr;
            wr_d2   <= wr_d1;
            rd_d1   <= psel_in & ~penable_in & ~pwrite_in;
            chan_d1 <= supply_channel_on_out;
            chan_d2 <= chan_d1;
            pin_d1  <= ext_ctrl_line_in;
            quiet   <= next_quiet;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    a_out_gated: assert property (!(|(ext_ctrl_line_out & ~ext_ctrl_line_oe_out)))
        else $error("line value while not an output");
    a_ready_high: assert property (pready_out)
        else $error("ready low");
    a_bad_addr_err: assert property (psel_in && penable_in
        && (paddr_in[1:0] != 2'h0 || paddr_in > 8'h18) |-> pslverr_out)
        else $error("no error on unmapped access");
    a_good_addr_ok: assert property (psel_in && penable_in
        && paddr_in[1:0] == 2'h0 && paddr_in <= 8'h18 |-> !pslverr_out)
        else $error("error on mapped access");
    a_bad_read_zero: assert property (psel_in && !penable_in && !pwrite_in
        && paddr_in > 8'h18 |=> prdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_cause: assert property ($changed(prdata_out) |-> rd_d1)
        else $error("read data moved without a read");
    a_oe_by_write: assert property ($changed(ext_ctrl_line_oe_out) |-> wr_d1 || wr_d2)
        else $error("direction changed without a write");
    a_out_cause: assert property ($changed(ext_ctrl_line_out)
        |-> wr_d1 || wr_d2 || chan_d1 != chan_d2)
        else $error("line value changed without cause");
    a_chan_cause: assert property ($changed(supply_channel_on_out) |-> quiet < 6'd30)
        else $error("channel changed without cause");
endmodule : ext_ctrl_io_properties

bind ext_ctrl_io ext_ctrl_io_properties u_props
(
    .clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .ext_ctrl_line_in(ext_ctrl_line_in), .ext_ctrl_line_out(ext_ctrl_line_out),
    .ext_ctrl_line_oe_out(ext_ctrl_line_oe_out),
    .supply_channel_on_out(supply_channel_on_out)
);

// ==== verification/ext_contact_model.sv ====
// external contacts on the control lines, resolved against the block's drivers
`timescale 1ns/1ps

module ext_contact_model
(
    input  wire logic [4:0] level_in,
    input  wire logic [4:0] drive_in,
    input  wire logic [4:0] oe_in,
    output logic      [4:0] wire_out
);
    // a driven output line overrides the weaker contact
    assign wire_out = (oe_in & drive_in) | (~oe_in & level_in);
endmodule : ext_contact_model

// ==== verification/ext_ctrl_io_test.sv ====
// self-checking bench of the external control line block
`timescale 1ns/1ps

module ext_ctrl_io_test;
    logic        clk_in    = 1'b0;
    logic        resetn_in = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0;
    logic [4:0]  level     = 5'h00;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [4:0]  pins;
    logic [4:0]  drive;
    logic [4:0]  oe;
    logic [3:0]  chan;
    logic [31:0] rd;
    logic        err;
    int          n_errors  = 0;
    int          n_tests   = 0;
    int          cycles    = 0;

    always #5 clk_in = ~clk_in;

    ext_ctrl_io DUT (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .ext_ctrl_line_in(pins), .ext_ctrl_line_out(drive),
        .ext_ctrl_line_oe_out(oe), .supply_channel_on_out(chan));

    ext_contact_model contacts (.level_in(level), .drive_in(drive), .oe_in(oe),
        .wire_out(pins));

    task automatic final_report;
        if (n_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one transfer; request held until ready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pin(input int k, input logic v);
        @(posedge clk_in);
        level[k] <= v;
    endtask : pin

    // bounded wait for the masked channel state
    task automatic wait_chan(input logic [3:0] m, input logic [3:0] exp);
        int i;
        i = 0;
        while ((chan & m) !== exp && i < 40)
        begin
            @(posedge clk_in);
            i++;
        end
        chk("channel state", {28'h0, exp}, {28'h0, chan & m});
    endtask : wait_chan

    task automatic t_reset;
        apb(1'b0, 8'h00, 32'h0);
        chk("line0 config", 32'h0100_0010, rd);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped read", 32'h1, {rd[30:0], err});
        apb(1'b1, 8'h02, 32'h1);
        chk("misaligned write error", 32'h1, {31'h0, err});
    endtask : t_reset

    task automatic t_refuse;
        apb(1'b1, 8'h04, 32'h0100_0000);
        apb(1'b0, 8'h04, 32'h0);
        chk("empty mask refused", 32'h0100_0010, rd);
        apb(1'b1, 8'h04, 32'h0100_0011);
        apb(1'b1, 8'h04, 32'h0100_0081);
        apb(1'b0, 8'h04, 32'h0);
        chk("locked while enabled", 32'h0100_0011, rd);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b0, 8'h04, 32'h0);
        chk("only enable taken", 32'h0100_0010, rd);
    endtask : t_refuse

    task automatic t_edges;
        apb(1'b1, 8'h00, 32'h0001_0031);
        pin(0, 1'b1);
        wait_chan(4'h3, 4'h3);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h00, 32'h0000_0131);
        pin(0, 1'b0);
        wait_chan(4'h3, 4'h0);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h08, 32'h0002_0041);
        pin(2, 1'b1);
        wait_chan(4'h4, 4'h4);
        pin(2, 1'b0);
        repeat (4) @(posedge clk_in);
        pin(2, 1'b1);
        wait_chan(4'h4, 4'h0);
    endtask : t_edges

    task automatic t_level;
        apb(1'b1, 8'h18, 32'h1);
        apb(1'b1, 8'h04, 32'h0000_0211);
        pin(1, 1'b1);
        wait_chan(4'h1, 4'h0);
        apb(1'b1, 8'h18, 32'hF);
        repeat (3) @(posedge clk_in);
        chk("level holds off", 32'h0, {31'h0, chan[0]});
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h18, 32'h0);
        apb(1'b1, 8'h0C, 32'h0001_0381);
        wait_chan(4'h8, 4'h8);
    endtask : t_level

    task automatic t_change;
        apb(1'b1, 8'h0C, 32'h0);
        apb(1'b1, 8'h0C, 32'h0002_0480);
        apb(1'b0, 8'h0C, 32'h0);
        chk("toggle refused", 32'h0001_0480, rd);
        apb(1'b1, 8'h0C, 32'h0001_0481);
        apb(1'b1, 8'h18, 32'h0);
        pin(3, 1'b1);
        wait_chan(4'h8, 4'h8);
        apb(1'b1, 8'h18, 32'h0);
        pin(3, 1'b0);
        wait_chan(4'h8, 4'h8);
        apb(1'b1, 8'h0C, 32'h0);
    endtask : t_change

    task automatic t_output;
        apb(1'b1, 8'h10, 32'h0120_0003);
        apb(1'b1, 8'h18, 32'h4);
        repeat (3) @(posedge clk_in);
        chk("line4 enable", 32'h1, {31'h0, oe[4]});
        chk("line4 on", 32'h1, {31'h0, pins[4]});
        // filtered levels of lines 1, 2 and 4 high, no hits, line4 driven
        apb(1'b0, 8'h14, 32'h0);
        chk("status word", 32'h0010_0016, rd);
        apb(1'b1, 8'h18, 32'h0);
        repeat (3) @(posedge clk_in);
        chk("line4 off", 32'h0, {31'h0, pins[4]});
        apb(1'b1, 8'h10, 32'h0);
        apb(1'b1, 8'h10, 32'h1130_0003);
        repeat (3) @(posedge clk_in);
        chk("line4 negative", 32'h1, {31'h0, pins[4]});
        apb(1'b1, 8'h18, 32'h8);
        repeat (3) @(posedge clk_in);
        chk("line4 new source", 32'h0, {31'h0, pins[4]});
    endtask : t_output

    // short glitches must die in the filter; long ones must get through
    task automatic t_sens;
        apb(1'b1, 8'h18, 32'h0);
        apb(1'b1, 8'h00, 32'h0001_1011);
        pin(0, 1'b1);
        repeat (8) @(posedge clk_in);
        pin(0, 1'b0);
        repeat (30) @(posedge clk_in);
        chk("low sensitivity short pulse", 32'h0, {31'h0, chan[0]});
        pin(0, 1'b1);
        wait_chan(4'h1, 4'h1);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h00, 32'h0000_2111);
        pin(0, 1'b0);
        @(posedge clk_in);
        pin(0, 1'b1);
        repeat (20) @(posedge clk_in);
        chk("middle sensitivity short dip", 32'h1, {31'h0, chan[0]});
        pin(0, 1'b0);
        wait_chan(4'h1, 4'h0);
        apb(1'b1, 8'h00, 32'h0);
    endtask : t_sens

    initial
    begin
        repeat (12) @(posedge clk_in);
        resetn_in <= 1'b1;
        t_reset();
        t_refuse();
        t_edges();
        t_level();
        t_change();
        t_output();
        t_sens();
        final_report();
    end

    // hang guard; the whole run needs well under this many cycles
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            final_report();
        end
    end
endmodule : ext_ctrl_io_test
